/* design/digital_output_control.sv */
// wishbone register file and output stage for the digital outputs and indicators
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - inversion mask bit flips that output
// - force enable bit overrides normal output
// - forced output follows force level bit
// - applied pattern register shows driven bits
// - routing switch one selects routing sources
// - routing active ignores inversion and forcing masks
// - indicator bits gate green and red LEDs
// - indicator mask resets with both lamps enabled
// - per-output selector picks its signal source
// - three 16-bit selectors, entry count three
// - selectors reset to their default codes
// - low half special, high half physical
module digital_output_control (
  input wire logic mclk,                               // 10 MHz system clock
  input wire logic rst_n,                              // async reset, active low
  input wire logic wb_cyc_i,                           // bus cycle
  input wire logic wb_stb_i,                           // strobe
  input wire logic wb_we_i,                            // write when high
  input wire logic [7:0] wb_adr_i,                     // byte address
  input wire logic [3:0] wb_sel_i,                     // byte enables
  input wire logic [31:0] wb_dat_i,                    // write data
  output logic [31:0] wb_dat_o,                        // read data
  output logic wb_ack_o,                               // answer
  input wire logic [31:0] func_value,                  // functional output levels
  input wire logic [31:0] host_output_request_object,  // host output request word
  input wire logic [31:0] route_src,                   // internal routing sources
  input wire logic run_blink,                          // run flash pattern
  input wire logic fault_blink,                        // fault flash pattern
  output logic brake_out,                              // brake output level
  output logic output1_out,                            // output 1 level
  output logic output2_out,                            // output 2 level
  output logic green_run_indicator,                    // green status lamp
  output logic red_fault_indicator                     // red error lamp
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [31:0] invert_ff;       // output_invert_mask
  logic [31:0] force_en_ff;     // output_force_enable_mask
  logic [31:0] force_lvl_ff;    // output_force_level_mask
  logic [31:0] applied_ff;      // output_applied_pattern
  logic [31:0] route_sw_ff;     // output_routing_switch
  logic [31:0] ind_mask_ff;     // indicator_enable_mask
  logic [15:0] brake_sel_ff;    // brake_source_select
  logic [15:0] out1_sel_ff;     // output1_source_select
  logic [15:0] out2_sel_ff;     // output2_source_select
  logic ack_ff;                 // registered acknowledge
  logic [31:0] rdata_ff;        // registered read data
  logic brake_ff;               // brake pin flop
  logic out1_ff;                // output 1 pin flop
  logic out2_ff;                // output 2 pin flop
  logic green_ff;               // green lamp flop
  logic red_ff;                 // red lamp flop

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic take;                   // request accepted this edge
  logic wr_take;                // write accepted this edge
  logic [7:0] word_adr;         // word aligned address
  logic [31:0] nxt_rdata;       // read mux result

  // a request is taken once; the ack cycle itself is not a new request
  assign take = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_take = take & wb_we_i;
  assign word_adr = {wb_adr_i[7:2], 2'b00};

  // ----------------------------------------------------------------
  // mixer connection
  // ----------------------------------------------------------------
  dout_mix_if mix ();

  // only bit 0 of the switch word counts; other bits are kept for read back
  assign mix.invert_mask = invert_ff;
  assign mix.force_en_mask = force_en_ff;
  assign mix.force_lvl_mask = force_lvl_ff;
  assign mix.route_en = route_sw_ff[0];
  assign mix.brake_sel = brake_sel_ff;
  assign mix.out1_sel = out1_sel_ff;
  assign mix.out2_sel = out2_sel_ff;
  assign mix.func_value = func_value;
  assign mix.host_req = host_output_request_object;
  assign mix.route_src = route_src;

  output_mixer u_mixer (
    .mix (mix.mixer)
  );

  // ----------------------------------------------------------------
  // mask registers
  // ----------------------------------------------------------------
  // inversion mask, bit-aligned with the pattern
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      invert_ff <= dout_pkg::RST_MASK;
    end else if (wr_take && word_adr == dout_pkg::OFS_INVERT) begin
      invert_ff <= dout_pkg::lane_merge(invert_ff, wb_dat_i, wb_sel_i);
    end
  end

  // force enable mask
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      force_en_ff <= dout_pkg::RST_MASK;
    end else if (wr_take && word_adr == dout_pkg::OFS_FORCE_EN) begin
      force_en_ff <= dout_pkg::lane_merge(force_en_ff, wb_dat_i, wb_sel_i);
    end
  end

  // force level mask
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      force_lvl_ff <= dout_pkg::RST_MASK;
    end else if (wr_take && word_adr == dout_pkg::OFS_FORCE_LVL) begin
      force_lvl_ff <= dout_pkg::lane_merge(force_lvl_ff, wb_dat_i, wb_sel_i);
    end
  end

  // routing switch word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      route_sw_ff <= dout_pkg::RST_MASK;
    end else if (wr_take && word_adr == dout_pkg::OFS_ROUTE_SW) begin
      route_sw_ff <= dout_pkg::lane_merge(route_sw_ff, wb_dat_i, wb_sel_i);
    end
  end

  // indicator enable mask, both lamps on out of reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ind_mask_ff <= dout_pkg::RST_IND_MASK;
    end else if (wr_take && word_adr == dout_pkg::OFS_IND_MASK) begin
      ind_mask_ff <= dout_pkg::lane_merge(ind_mask_ff, wb_dat_i, wb_sel_i);
    end
  end

  // ----------------------------------------------------------------
  // routing selectors
  // ----------------------------------------------------------------
  // three 16-bit codes in the low half of their words; upper lanes dropped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      brake_sel_ff <= dout_pkg::RST_BRAKE_SEL;
      out1_sel_ff <= dout_pkg::RST_OUT1_SEL;
      out2_sel_ff <= dout_pkg::RST_OUT2_SEL;
    end else if (wr_take) begin
      case (word_adr)
        dout_pkg::OFS_BRAKE_SEL: begin
          brake_sel_ff <= 16'(dout_pkg::lane_merge({16'h0000, brake_sel_ff}, wb_dat_i, wb_sel_i));
        end
        dout_pkg::OFS_OUT1_SEL: begin
          out1_sel_ff <= 16'(dout_pkg::lane_merge({16'h0000, out1_sel_ff}, wb_dat_i, wb_sel_i));
        end
        dout_pkg::OFS_OUT2_SEL: begin
          out2_sel_ff <= 16'(dout_pkg::lane_merge({16'h0000, out2_sel_ff}, wb_dat_i, wb_sel_i));
        end
        default: begin
          // other words are handled by their own processes
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // applied pattern and pins
  // ----------------------------------------------------------------
  // pattern is recomputed every cycle, so a write to it cannot stick;
  // software writes there are accepted and discarded
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      applied_ff <= dout_pkg::RST_MASK;
    end else begin
      applied_ff <= mix.next_pattern;
    end
  end

  // physical pins sit in the upper half; lower half feeds special functions
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      brake_ff <= 1'b0;
      out1_ff <= 1'b0;
      out2_ff <= 1'b0;
    end else begin
      brake_ff <= mix.next_pattern[dout_pkg::BIT_BRAKE];
      out1_ff <= mix.next_pattern[dout_pkg::BIT_OUT1];
      out2_ff <= mix.next_pattern[dout_pkg::BIT_OUT2];
    end
  end

  // lamps follow their flash pattern only while enabled, dark otherwise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      green_ff <= 1'b0;
      red_ff <= 1'b0;
    end else begin
      green_ff <= ind_mask_ff[dout_pkg::BIT_GREEN] & run_blink;
      red_ff <= ind_mask_ff[dout_pkg::BIT_RED] & fault_blink;
    end
  end

  assign brake_out = brake_ff;
  assign output1_out = out1_ff;
  assign output2_out = out2_ff;
  assign green_run_indicator = green_ff;
  assign red_fault_indicator = red_ff;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // spare words and unmapped addresses read zero; they still get an ack
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (word_adr)
      dout_pkg::OFS_INVERT: begin
        nxt_rdata = invert_ff;
      end
      dout_pkg::OFS_FORCE_EN: begin
        nxt_rdata = force_en_ff;
      end
      dout_pkg::OFS_FORCE_LVL: begin
        nxt_rdata = force_lvl_ff;
      end
      dout_pkg::OFS_APPLIED: begin
        nxt_rdata = applied_ff;
      end
      dout_pkg::OFS_ROUTE_SW: begin
        nxt_rdata = route_sw_ff;
      end
      dout_pkg::OFS_IND_MASK: begin
        nxt_rdata = ind_mask_ff;
      end
      dout_pkg::OFS_ENTRY_CNT: begin
        nxt_rdata = {24'h00_0000, dout_pkg::ENTRY_COUNT};
      end
      dout_pkg::OFS_BRAKE_SEL: begin
        nxt_rdata = {16'h0000, brake_sel_ff};
      end
      dout_pkg::OFS_OUT1_SEL: begin
        nxt_rdata = {16'h0000, out1_sel_ff};
      end
      dout_pkg::OFS_OUT2_SEL: begin
        nxt_rdata = {16'h0000, out2_sel_ff};
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // acknowledge
  // ----------------------------------------------------------------
  // one wait-free cycle: ack in the cycle after the request, dropped after one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= take;
    end
  end

  // read data captured with the ack; held stable otherwise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (take && !wb_we_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

endmodule : digital_output_control
`default_nettype wire

/* common/dout_pkg.sv */
// constants, offsets and helper functions for the digital output control block
`default_nettype none
package dout_pkg;

  // ----------------------------------------------------------------
  // register byte offsets (one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_INVERT = 8'h00;        // output_invert_mask
  localparam logic [7:0] OFS_FORCE_EN = 8'h04;      // output_force_enable_mask
  localparam logic [7:0] OFS_FORCE_LVL = 8'h08;     // output_force_level_mask
  localparam logic [7:0] OFS_APPLIED = 8'h0c;       // output_applied_pattern
  localparam logic [7:0] OFS_SPARE_ONE = 8'h10;     // spare_word_one
  localparam logic [7:0] OFS_SPARE_TWO = 8'h14;     // spare_word_two
  localparam logic [7:0] OFS_ROUTE_SW = 8'h18;      // output_routing_switch
  localparam logic [7:0] OFS_IND_MASK = 8'h1c;      // indicator_enable_mask
  localparam logic [7:0] OFS_ENTRY_CNT = 8'h20;     // routing_entry_count
  localparam logic [7:0] OFS_BRAKE_SEL = 8'h24;     // brake_source_select
  localparam logic [7:0] OFS_OUT1_SEL = 8'h28;      // output1_source_select
  localparam logic [7:0] OFS_OUT2_SEL = 8'h2c;      // output2_source_select

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_IND_MASK = 32'h0fff_ffff;
  localparam logic [7:0] ENTRY_COUNT = 8'h03;
  localparam logic [15:0] RST_BRAKE_SEL = 16'h1080;
  localparam logic [15:0] RST_OUT1_SEL = 16'h0090;
  localparam logic [15:0] RST_OUT2_SEL = 16'h0091;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_BRAKE = 16;           // physical brake level
  localparam int unsigned BIT_OUT1 = 17;            // physical output 1 level
  localparam int unsigned BIT_OUT2 = 18;            // physical output 2 level
  localparam int unsigned BIT_GREEN = 0;            // run indicator enable
  localparam int unsigned BIT_RED = 1;              // fault indicator enable
  localparam int unsigned SEL_INV_BIT = 12;         // selector: invert routed source
  localparam logic [2:0] SEL_HOST_GRP = 3'h4;       // code[7:5]=100 -> host request bit
  localparam logic [2:0] SEL_SRC_GRP = 3'h0;        // code[7:5]=000 -> internal source bit

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge of a wishbone write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val, input logic [31:0] wr_val,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wr_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // level delivered by one routing selector code
  function automatic logic pick_source(input logic [15:0] code, input logic [31:0] host_req,
                                       input logic [31:0] src);
    logic lvl;
    lvl = 1'b0;
    if (code[7:5] == SEL_HOST_GRP) begin
      lvl = host_req[code[4:0]];
    end else if (code[7:5] == SEL_SRC_GRP) begin
      lvl = src[code[4:0]];
    end
    return lvl ^ code[SEL_INV_BIT];
  endfunction : pick_source

endpackage : dout_pkg
`default_nettype wire

/* common/dout_mix_if.sv */
// bundle between the register file and the output mixer
`timescale 1ns/1ps
`default_nettype none
interface dout_mix_if;
  logic [31:0] invert_mask;      // inversion bits
  logic [31:0] force_en_mask;    // force enable bits
  logic [31:0] force_lvl_mask;   // forced levels
  logic route_en;                // routing mechanism active
  logic [15:0] brake_sel;        // brake source code
  logic [15:0] out1_sel;         // output 1 source code
  logic [15:0] out2_sel;         // output 2 source code
  logic [31:0] func_value;       // normal functional levels
  logic [31:0] host_req;         // host output request word
  logic [31:0] route_src;        // internal routing sources
  logic [31:0] next_pattern;     // mixed result

  modport regs (output invert_mask, output force_en_mask, output force_lvl_mask, output route_en,
                output brake_sel, output out1_sel, output out2_sel, output func_value,
                output host_req, output route_src, input next_pattern);
  modport mixer (input invert_mask, input force_en_mask, input force_lvl_mask, input route_en,
                 input brake_sel, input out1_sel, input out2_sel, input func_value,
                 input host_req, input route_src, output next_pattern);
endinterface : dout_mix_if
`default_nettype wire

/* design/output_mixer.sv */
// combinational mixing of function, inversion, forcing and routing
`timescale 1ns/1ps
`default_nettype none
module output_mixer (
  dout_mix_if.mixer mix
);

  // ----------------------------------------------------------------
  // mask path
  // ----------------------------------------------------------------
  logic [31:0] inverted;   // functional value after inversion
  logic [31:0] masked;     // after forcing

  // inversion then forcing, bit by bit
  always_comb begin
    inverted = mix.func_value ^ mix.invert_mask;
    masked = (mix.force_en_mask & mix.force_lvl_mask) | (~mix.force_en_mask & inverted);
  end

  // ----------------------------------------------------------------
  // routing path
  // ----------------------------------------------------------------
  logic [31:0] routed;     // pattern while routing owns the outputs

  // masks are bypassed entirely; only the three physical levels are replaced
  always_comb begin
    routed = mix.func_value;
    routed[dout_pkg::BIT_BRAKE] = dout_pkg::pick_source(mix.brake_sel, mix.host_req, mix.route_src);
    routed[dout_pkg::BIT_OUT1] = dout_pkg::pick_source(mix.out1_sel, mix.host_req, mix.route_src);
    routed[dout_pkg::BIT_OUT2] = dout_pkg::pick_source(mix.out2_sel, mix.host_req, mix.route_src);
  end

  // routing switch chooses the path
  assign mix.next_pattern = mix.route_en ? routed : masked;

endmodule : output_mixer
`default_nettype wire

/* verification/digital_output_control_props.sv */
// concurrent checks on the ports of the digital output control block
`timescale 1ns/1ps
`default_nettype none
module digital_output_control_props (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [31:0] func_value,
  input wire logic [31:0] host_output_request_object,
  input wire logic [31:0] route_src,
  input wire logic run_blink,
  input wire logic fault_blink,
  input wire logic brake_out,
  input wire logic output1_out,
  input wire logic output2_out,
  input wire logic green_run_indicator,
  input wire logic red_fault_indicator
);
  // ----------------------------------------------------------------
  // one domain, so one default clock and disable
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // request seen while no answer is pending
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // read answer on the bus
  sequence rd_ack_s;
    wb_ack_o && !wb_we_i;
  endsequence
  a_ack_after_take: assert property (take_s |=> wb_ack_o) else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_entry_count_three: assert property ((rd_ack_s ##0 wb_adr_i[7:2] == 6'h08) |-> wb_dat_o == 32'h0000_0003)
    else $error("entry count not three");
  a_spare_reads_zero: assert property ((rd_ack_s ##0 (wb_adr_i[7:2] inside {6'h04, 6'h05} || wb_adr_i >= 8'h30))
    |-> wb_dat_o == 32'h0) else $error("spare or unmapped read not zero");
  a_sel_upper_zero: assert property ((rd_ack_s ##0 wb_adr_i[7:2] inside {6'h09, 6'h0a, 6'h0b})
    |-> wb_dat_o[31:16] == 16'h0) else $error("selector upper half not zero");
  a_green_gated: assert property (green_run_indicator |-> $past(run_blink)) else $error("green lit without pattern");
  a_red_gated: assert property (red_fault_indicator |-> $past(fault_blink)) else $error("red lit without pattern");
endmodule : digital_output_control_props
bind digital_output_control digital_output_control_props u_props (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .func_value(func_value),
  .host_output_request_object(host_output_request_object), .route_src(route_src), .run_blink(run_blink),
  .fault_blink(fault_blink), .brake_out(brake_out), .output1_out(output1_out), .output2_out(output2_out),
  .green_run_indicator(green_run_indicator), .red_fault_indicator(red_fault_indicator));
`default_nettype wire

/* verification/output_load_model.sv */
// model of the loads hung on the outputs: brake, two outputs and two lamps
`timescale 1ns/1ps
`default_nettype none
module output_load_model (
  input wire logic brake_out,
  input wire logic output1_out,
  input wire logic output2_out,
  input wire logic green_run_indicator,
  input wire logic red_fault_indicator,
  output logic [4:0] load_seen
);
  // ----------------------------------------------------------------
  // loads are passive: they show what is driven, no filtering
  // ----------------------------------------------------------------
  assign load_seen = {red_fault_indicator, green_run_indicator, output2_out, output1_out, brake_out};
endmodule : output_load_model
`default_nettype wire

/* verification/digital_output_control_tb.sv */
// register-level self-checking bench for the digital output control block
`timescale 1ns/1ps
`default_nettype none
module digital_output_control_tb;
  logic mclk = 1'b0;                 // 10 MHz clock
  logic rst_n = 1'b0;                // held low at start
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, func = 32'h0, host = 32'h0, rsrc = 32'h0;
  logic run_b = 1'b0, fault_b = 1'b0;  // lamp flash patterns
  logic [31:0] dat_o;
  logic ack, brk, o1, o2, grn, red;
  logic [4:0] load_seen;             // what the loads show
  int failures = 0;
  int comparisons = 0;
  // reset values in address order 0x00..0x2c
  logic [31:0] rst_tbl [12] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0fff_ffff, 32'h3,
                                 32'h1080, 32'h0090, 32'h0091};
  always #50 mclk = ~mclk;
  digital_output_control dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .func_value(func),
    .host_output_request_object(host), .route_src(rsrc), .run_blink(run_b), .fault_blink(fault_b),
    .brake_out(brk), .output1_out(o1), .output2_out(o2), .green_run_indicator(grn), .red_fault_indicator(red));
  output_load_model u_load (.brake_out(brk), .output1_out(o1), .output2_out(o2), .green_run_indicator(grn),
    .red_fault_indicator(red), .load_seen(load_seen));
  // ----------------------------------------------------------------
  // report helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // ----------------------------------------------------------------
  // classic wishbone master; caller stands just after a rising edge
  // ----------------------------------------------------------------
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (ack === 1'b1) begin
        rdat = dat_o;  // taken at the ack edge only
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge mclk);  // idle cycle between transfers
        return;
      end
    end
    failures++;  // answer never came
    test_done();
  endtask : wb_cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    wb_cycle(1'b1, a, d, s);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb_cycle(1'b0, a, 32'h0, 4'hf);
    check(rdat, exp);
  endtask : rd_chk
  // pins lag their causes by one edge; two edges leave margin
  task automatic pins(input logic [4:0] exp);
    repeat (2) @(posedge mclk);
    check({27'h0, load_seen}, {27'h0, exp});
  endtask : pins
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 12; i++) rd_chk(8'(i * 4), rst_tbl[i]);
    pins(5'h00);
    $display("test reset_values done");
    func <= 32'h0005_a5a5;
    wr(8'h00, 32'h0003_00ff);
    rd_chk(8'h0c, 32'h0006_a55a);
    pins(5'h06);
    $display("test invert done");
    wr(8'h04, 32'h0005_0002);
    wr(8'h08, 32'h0001_0000);
    rd_chk(8'h0c, 32'h0003_a558);
    pins(5'h03);
    wr(8'h0c, 32'hffff_ffff);  // read-only word, write dropped
    rd_chk(8'h0c, 32'h0003_a558);
    wr(8'h10, 32'hffff_ffff);  // spare word
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h40, 32'h0);      // unmapped
    $display("test force done");
    host <= 32'h0001_0001;
    wr(8'h18, 32'h1);
    rd_chk(8'h0c, 32'h0002_a5a5);
    pins(5'h02);
    rsrc <= 32'h8;
    wr(8'h2c, 32'hffff_0003);
    rd_chk(8'h2c, 32'h0000_0003);
    pins(5'h06);
    wr(8'h24, 32'h0000_0085, 4'h1);  // low lane only, high lane kept
    rd_chk(8'h24, 32'h0000_1085);
    pins(5'h07);
    wr(8'h18, 32'h0);
    rd_chk(8'h0c, 32'h0003_a558);
    $display("test routing done");
    run_b <= 1'b1;
    fault_b <= 1'b1;
    pins(5'h1b);
    wr(8'h1c, 32'h1);
    pins(5'h0b);
    wr(8'h1c, 32'h2);
    pins(5'h13);
    $display("test indicators done");
    test_done();
  end
endmodule : digital_output_control_tb
`default_nettype wire
